// *** hw/dacrb_pkg.sv ***
package dacrb_pkg;
    localparam int          DW          = 16;
    localparam int          NCH         = 16;
    localparam int          GRP         = 8;
    localparam int          FRAME_W     = 24;
    localparam logic [4:0]  FRAME_BITS  = 5'h18;
    // request kinds carried in the address byte
    localparam logic [2:0]  KIND_INPUT   = 3'h0;
    localparam logic [2:0]  KIND_GAIN    = 3'h1;
    localparam logic [2:0]  KIND_OFFS    = 3'h2;
    localparam logic [2:0]  KIND_SPECIAL = 3'h3;
    localparam logic [2:0]  KIND_INPUT_B = 3'h4;
    // special register numbers in the channel field
    localparam logic [3:0]  SPC_CONTROL  = 4'h0;
    localparam logic [3:0]  SPC_MONITOR  = 4'h1;
    localparam logic [3:0]  SPC_GPIO     = 4'h2;
    localparam logic [3:0]  SPC_GRP0_OFS = 4'h3;
    localparam logic [3:0]  SPC_GRP1_OFS = 4'h4;
    localparam logic [3:0]  SPC_ABSEL0   = 4'h5;
    localparam logic [3:0]  SPC_ABSEL1   = 4'h6;
    // control and gpio register fields, monitor and offset widths
    localparam int          CTL_TEMP_EN   = 0;
    localparam int          CTL_PWR_DOWN  = 1;
    localparam int          CTL_BANK_SEL  = 2;
    localparam int          CTL_PKT_ERR   = 3;
    localparam int          CTL_OVER_TEMP = 4;
    localparam int          GPIO_DATA     = 0;
    localparam int          GPIO_DIR      = 1;
    localparam int          MON_W         = 6;
    localparam int          OFS_W         = 14;
    // reset values and calibration midscale
    localparam logic [15:0] INPUT_RST   = 16'h8000;
    localparam logic [15:0] GAIN_RST    = 16'hFFFF;
    localparam logic [15:0] OFFS_RST    = 16'h8000;
    localparam logic [15:0] CAL_RST     = 16'h8000;
    localparam logic [13:0] GRP_OFS_RST = 14'h2000;
    localparam logic [16:0] CAL_BIAS    = 17'h08000;
    // synchroniser lanes
    localparam int          PIN_N       = 7;
    localparam int          PIN_SCLK    = 0;
    localparam int          PIN_FRAME   = 1;
    localparam int          PIN_DIN     = 2;
    localparam int          PIN_LOAD    = 3;
    localparam int          PIN_CODING  = 4;
    localparam int          PIN_HOT     = 5;
    localparam int          PIN_GPIO    = 6;
    localparam logic [6:0]  PIN_RST     = 7'h0A;

    typedef struct packed {
        logic        rd;
        logic [2:0]  kind;
        logic [3:0]  chan;
        logic [15:0] data;
    } dacrb_frame_t;
endpackage

// *** hw/dacrb_calc.sv ***
`timescale 1ns/1ps
module dacrb_calc
    import dacrb_pkg::*;
(
    input  wire logic [DW-1:0] x,
    input  wire logic [DW-1:0] m,
    input  wire logic [DW-1:0] c,
    output logic      [DW-1:0] y
);
    // (R21) shared multiply-add
    logic [16:0] m_plus;
    logic [32:0] prod;
    logic [18:0] sum;
    assign m_plus = {1'b0, m} + 17'h00001;
    assign prod   = {17'h00000, x} * {16'h0000, m_plus};
    // scaled + c - midscale, kept signed in 19 bits
    assign sum    = {2'b00, prod[32:16]} + {3'b000, c} - {2'b00, CAL_BIAS};
    // saturate rather than wrap: a wrapped code would swing the output rail to rail
    assign y      = sum[18] ? 16'h0000 : (|sum[17:16] ? 16'hFFFF : sum[15:0]);
endmodule

// *** hw/dacrb_bank.sv ***
`timescale 1ns/1ps
// How it works
// (R1) coding_select high converts two's complement input data to offset binary.
// (R2) channels 0-7 form group zero, 8-15 group one, for shared settings.
// (R3) each channel has writable input bank first and bank second registers.
// (R4) each channel has a writable gain trim scaling its input data.
// (R5) each channel has a writable offset trim added after scaling.
// (R6) calibrated first/second registers hold results, never host readable or writable.
// (R7) final converter register loads only from a calibrated register.
// (R8) two writable 14-bit group offset levels, one per group.
// (R9) control bit 4 reads the over-temperature indication.
// (R10) control bit 3 sets on a packet failure, clears when control is read.
// (R11) control bit 2 steers all input writes to bank first or second.
// (R12) control bit 1 commands soft power-down of the outputs.
// (R13) control bit 0 enables automatic thermal shutdown.
// (R14) monitor bit 5 enables the mux; bits 3-0 pick the channel.
// (R15) monitor bit 4 routes external input zero or one per bit 0.
// (R16) gpio bit 1 sets the pin direction, 1 meaning output.
// (R17) gpio bit 0 captures the pin as input, drives it as output.
// (R18) writes to input, gain or offset trim recompute the matching calibrated bank.
// (R19) per-group 8-bit select picks calibrated first or second per channel.
// (R20) load_outputs_n falling copies the selected calibrated values to converters.
// (R21) one multiplier and adder serve all channels, one update per cycle.
// (R22) unused upper bits read zero and ignore writes.
module dacrb_bank
    import dacrb_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                rst_b,
    input  wire logic                spi_clk,
    input  wire logic                spi_frame_n,
    input  wire logic                spi_din,
    output logic                     spi_dout,
    input  wire logic                load_outputs_n,
    input  wire logic                coding_select,
    input  wire logic                over_temp,
    input  wire logic                gpio_in,
    output logic                     gpio_out,
    output logic                     gpio_oe,
    output logic                     outputs_powered_down,
    output logic                     temp_shutdown_en,
    output logic [MON_W-1:0]         monitor_select,
    output logic [OFS_W-1:0]         group0_offset_level,
    output logic [OFS_W-1:0]         group1_offset_level,
    output logic [NCH*DW-1:0]        dac_code
);
    logic [PIN_N-1:0]   s1, s2, s3, lvl, lvl_d;
    logic [4:0]         bit_cnt;
    logic [FRAME_W-1:0] rx, tx, read_word;
    logic [DW-1:0]      input_bank_first  [NCH];
    logic [DW-1:0]      input_bank_second [NCH];
    logic [DW-1:0]      gain_trim         [NCH];
    logic [DW-1:0]      offset_trim       [NCH];
    logic [DW-1:0]      calibrated_first  [NCH];
    logic [DW-1:0]      calibrated_second [NCH];
    logic [DW-1:0]      dac_reg           [NCH];
    logic [2*NCH-1:0]   pend, next_pend, set_mask, done_mask;
    logic [NCH-1:0]     absel;
    logic               temp_en, pwr_down, bank_sel, packet_check_flag;
    logic               gpio_dir, gpio_data;

    // pins from outside: three flops, a change counts once the 2nd and 3rd agree
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            s1    <= PIN_RST;
            s2    <= PIN_RST;
            s3    <= PIN_RST;
            lvl   <= PIN_RST;
            lvl_d <= PIN_RST;
        end else begin
            s1    <= {gpio_in, over_temp, coding_select, load_outputs_n,
                      spi_din, spi_frame_n, spi_clk};
            s2    <= s1;
            s3    <= s2;
            lvl   <= (s2 & s3) | (lvl & (s2 ^ s3));
            lvl_d <= lvl;
        end
    end

    logic sclk_rise, sclk_fall, frame_start, frame_end, frame_on, load_fall, ot, twos;
    assign sclk_rise   = lvl[PIN_SCLK] & ~lvl_d[PIN_SCLK];
    assign sclk_fall   = ~lvl[PIN_SCLK] & lvl_d[PIN_SCLK];
    assign frame_start = ~lvl[PIN_FRAME] & lvl_d[PIN_FRAME];
    assign frame_end   = lvl[PIN_FRAME] & ~lvl_d[PIN_FRAME];
    assign frame_on    = ~lvl[PIN_FRAME];
    assign load_fall   = ~lvl[PIN_LOAD] & lvl_d[PIN_LOAD];
    assign ot          = lvl[PIN_HOT];
    assign twos        = lvl[PIN_CODING];

    // serial port: sample on clock rise, shift out on clock fall
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            bit_cnt <= 5'h00;
            rx      <= 24'h000000;
            tx      <= 24'h000000;
        end else if (frame_start) begin
            bit_cnt <= 5'h00;
            tx      <= read_word;
        end else if (frame_on && sclk_rise) begin
            rx      <= {rx[FRAME_W-2:0], lvl[PIN_DIN]};
            bit_cnt <= (bit_cnt == 5'h1F) ? bit_cnt : bit_cnt + 5'h01;
        end else if (frame_on && sclk_fall) begin
            tx      <= {tx[FRAME_W-2:0], 1'b0};
        end
    end
    assign spi_dout = tx[FRAME_W-1];

    dacrb_frame_t f;
    logic         commit, bad_frame, wr, rd, is_spc;
    assign f         = dacrb_frame_t'(rx);
    assign commit    = frame_end && (bit_cnt == FRAME_BITS);
    assign bad_frame = frame_end && (bit_cnt != FRAME_BITS) && (bit_cnt != 5'h00);
    assign wr        = commit && !f.rd;
    assign rd        = commit && f.rd;
    assign is_spc    = f.kind == KIND_SPECIAL;

    // (R1) convert two's complement to offset binary by flipping the sign bit
    logic [DW-1:0] in_code;
    assign in_code = twos ? {~f.data[DW-1], f.data[DW-2:0]} : f.data;

    // (R22) narrow registers read back zero-extended
    function automatic logic [DW-1:0] rd_mux(input dacrb_frame_t a);
        logic [DW-1:0] r;
        r = 16'h0000;
        case (a.kind)
            KIND_INPUT:   r = input_bank_first[a.chan];
            KIND_INPUT_B: r = input_bank_second[a.chan];
            KIND_GAIN:    r = gain_trim[a.chan];
            KIND_OFFS:    r = offset_trim[a.chan];
            KIND_SPECIAL: begin
                case (a.chan)
                    // (R9) live over-temperature bit
                    SPC_CONTROL:  r = {11'h000, ot, packet_check_flag, bank_sel,
                                       pwr_down, temp_en};
                    SPC_MONITOR:  r = {10'h000, monitor_select};
                    // (R17) input mode reads the synchronised pin
                    SPC_GPIO:     r = {14'h0000, gpio_dir, gpio_dir ? gpio_data : lvl[PIN_GPIO]};
                    SPC_GRP0_OFS: r = {2'b00, group0_offset_level};
                    SPC_GRP1_OFS: r = {2'b00, group1_offset_level};
                    SPC_ABSEL0:   r = {8'h00, absel[GRP-1:0]};
                    SPC_ABSEL1:   r = {8'h00, absel[NCH-1:GRP]};
                    default:      r = 16'h0000;
                endcase
            end
            default:      r = 16'h0000;
        endcase
        return r;
    endfunction

    // control, monitor, gpio, group settings
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            temp_en             <= 1'b0;
            pwr_down            <= 1'b0;
            bank_sel            <= 1'b0;
            packet_check_flag   <= 1'b0;
            monitor_select      <= 6'h00;
            gpio_dir            <= 1'b0;
            gpio_data           <= 1'b0;
            group0_offset_level <= GRP_OFS_RST;
            group1_offset_level <= GRP_OFS_RST;
            absel               <= 16'h0000;
            read_word           <= 24'h000000;
        end else begin
            // (R10) a failing frame wins over the clearing read
            if (bad_frame)
                packet_check_flag <= 1'b1;
            else if (rd && is_spc && f.chan == SPC_CONTROL)
                packet_check_flag <= 1'b0;
            if (rd)
                read_word <= {8'h00, rd_mux(f)};
            if (wr && is_spc) begin
                case (f.chan)
                    // (R11) (R12) (R13) writable control bits; status bits ignore writes
                    SPC_CONTROL: begin
                        temp_en  <= f.data[CTL_TEMP_EN];
                        pwr_down <= f.data[CTL_PWR_DOWN];
                        bank_sel <= f.data[CTL_BANK_SEL];
                    end
                    // (R14) (R15) mux enable, external flag and selection
                    SPC_MONITOR:  monitor_select <= f.data[MON_W-1:0];
                    // (R16) (R17) direction and driven level
                    SPC_GPIO: begin
                        gpio_dir  <= f.data[GPIO_DIR];
                        gpio_data <= f.data[GPIO_DATA];
                    end
                    // (R8) (R22) 14-bit group offsets, upper bits dropped
                    SPC_GRP0_OFS: group0_offset_level <= f.data[OFS_W-1:0];
                    SPC_GRP1_OFS: group1_offset_level <= f.data[OFS_W-1:0];
                    // (R19) (R2) one select byte per group
                    SPC_ABSEL0:   absel[GRP-1:0]   <= f.data[GRP-1:0];
                    SPC_ABSEL1:   absel[NCH-1:GRP] <= f.data[GRP-1:0];
                    default:      ;
                endcase
            end
        end
    end

    // thermal shutdown only acts while enabled
    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            outputs_powered_down <= 1'b0;
            temp_shutdown_en     <= 1'b0;
            gpio_out             <= 1'b0;
            gpio_oe              <= 1'b0;
        end else begin
            // (R12) (R13) soft or thermal power-down
            outputs_powered_down <= pwr_down | (temp_en & ot);
            temp_shutdown_en     <= temp_en;
            gpio_out             <= gpio_data;
            gpio_oe              <= gpio_dir;
        end
    end

    // lowest pending index first; index is {bank, channel}
    function automatic logic [4:0] first_set(input logic [2*NCH-1:0] v);
        logic [4:0] idx;
        idx = 5'h00;
        for (int i = 2*NCH-1; i >= 0; i--) begin
            if (v[i])
                idx = 5'(i);
        end
        return idx;
    endfunction

    logic          sel_valid, set_bank;
    logic [4:0]    sel_idx;
    logic [3:0]    sel_ch;
    logic [DW-1:0] calc_x, calc_y;
    assign sel_valid = |pend;
    assign sel_idx   = first_set(pend);
    assign sel_ch    = sel_idx[3:0];
    assign calc_x    = sel_idx[4] ? input_bank_second[sel_ch] : input_bank_first[sel_ch];
    // (R18) input writes mark their bank, trim writes the bank that control bit 2 names
    assign set_bank  = bank_sel;
    assign set_mask  = (wr && (f.kind == KIND_INPUT || f.kind == KIND_GAIN
                        || f.kind == KIND_OFFS)) ? (32'h1 << {set_bank, f.chan}) : 32'h0;
    assign done_mask = sel_valid ? (32'h1 << sel_idx) : 32'h0;
    // a write landing on the entry being computed keeps it pending
    assign next_pend = (pend & ~done_mask) | set_mask;

    // (R21) one channel through the datapath per cycle
    dacrb_calc u_calc (
        .x (calc_x),
        .m (gain_trim[sel_ch]),
        .c (offset_trim[sel_ch]),
        .y (calc_y)
    );

    always_ff @(posedge ref_clk) begin
        if (!rst_b) begin
            pend <= 32'h0;
            for (int i = 0; i < NCH; i++) begin
                input_bank_first[i]  <= INPUT_RST;
                input_bank_second[i] <= INPUT_RST;
                gain_trim[i]         <= GAIN_RST;
                offset_trim[i]       <= OFFS_RST;
                calibrated_first[i]  <= CAL_RST;
                calibrated_second[i] <= CAL_RST;
                dac_reg[i]           <= CAL_RST;
            end
        end else begin
            pend <= next_pend;
            if (wr) begin
                case (f.kind)
                    // (R3) (R11) bank chosen globally by control bit 2
                    KIND_INPUT: begin
                        if (bank_sel)
                            input_bank_second[f.chan] <= in_code;
                        else
                            input_bank_first[f.chan]  <= in_code;
                    end
                    // (R4) gain trim
                    KIND_GAIN:  gain_trim[f.chan]   <= f.data;
                    // (R5) offset trim
                    KIND_OFFS:  offset_trim[f.chan] <= f.data;
                    default:    ;
                endcase
            end
            // (R6) calibrated registers written only by the datapath
            if (sel_valid) begin
                if (sel_idx[4])
                    calibrated_second[sel_ch] <= calc_y;
                else
                    calibrated_first[sel_ch]  <= calc_y;
            end
            // (R20) (R7) simultaneous load from the selected calibrated bank
            if (load_fall) begin
                for (int i = 0; i < NCH; i++)
                    dac_reg[i] <= absel[i] ? calibrated_second[i] : calibrated_first[i];
            end
        end
    end

    for (genvar g = 0; g < NCH; g++) begin : g_out
        assign dac_code[g*DW +: DW] = dac_reg[g];
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_b);

    sequence s_bad_frame;
        bad_frame;
    endsequence
    sequence s_ctrl_read;
        rd && is_spc && f.chan == SPC_CONTROL;
    endsequence

    pec_set_a: assert property (s_bad_frame |=> packet_check_flag) // (R10)
        else $error("packet flag not set after bad frame");
    pec_clear_a: assert property (s_ctrl_read |=> !packet_check_flag) // (R10)
        else $error("packet flag not cleared by control read");
    bank_steer_a: assert property (wr && f.kind == KIND_INPUT && !bank_sel // (R11)
        |=> input_bank_first[$past(f.chan)] == $past(in_code))
        else $error("input write missed bank first");
    coding_conv_a: assert property (wr && f.kind == KIND_INPUT && twos // (R1)
        |=> (bank_sel ? input_bank_second[$past(f.chan)]
                      : input_bank_first[$past(f.chan)]) == {~$past(f.data[15]), $past(f.data[14:0])})
        else $error("two's complement input not converted");
    recalc_mark_a: assert property (set_mask != 32'h0 |=> (pend & $past(set_mask)) != 32'h0) // (R18)
        else $error("recalculation not scheduled");
    cal_update_a: assert property (sel_valid && !sel_idx[4] // (R21)
        |=> calibrated_first[$past(sel_ch)] == $past(calc_y))
        else $error("calibrated first not updated");
    dac_load_a: assert property (load_fall // (R20)
        |=> dac_reg[0] == ($past(absel[0]) ? $past(calibrated_second[0])
                                           : $past(calibrated_first[0])))
        else $error("converter register not loaded");
    power_down_a: assert property (pwr_down || (temp_en && ot) |=> outputs_powered_down) // (R12)
        else $error("outputs not powered down");
    temp_off_a: assert property (!pwr_down && !temp_en |=> !outputs_powered_down) // (R13)
        else $error("thermal shutdown acted while disabled");
    gpio_pin_a: assert property (gpio_oe |-> gpio_out == $past(gpio_data)) // (R17)
        else $error("gpio not driving stored level");
    narrow_read_a: assert property (rd && is_spc && f.chan == SPC_GRP0_OFS // (R22)
        |=> read_word[FRAME_W-1:OFS_W] == 10'h000)
        else $error("upper offset bits not zero");
endmodule

// *** tb/dacrb_host.sv ***
`timescale 1ns/1ps
module dacrb_host (
    input  wire logic ref_clk,
    input  wire logic spi_dout,
    output logic      spi_clk,
    output logic      spi_frame_n,
    output logic      spi_din,
    output logic      load_outputs_n
);
    // half of the 160 ns serial clock in ref_clk cycles
    localparam int HALF = 10;

    initial begin
        spi_clk = 1'b0;
        spi_frame_n = 1'b1;
        spi_din = 1'b0;
        load_outputs_n = 1'b1;
    end

    // serial clock stands low between frames; short frames are allowed on purpose
    task automatic xfer(input logic [23:0] word, input int nbits, output logic [23:0] rx);
        rx = '0;
        @(posedge ref_clk);
        spi_frame_n <= 1'b0;
        for (int i = 0; i < nbits; i++) begin
            spi_din <= word[23-i];
            repeat (HALF) @(posedge ref_clk);
            rx = {rx[22:0], spi_dout};
            spi_clk <= 1'b1;
            repeat (HALF) @(posedge ref_clk);
            spi_clk <= 1'b0;
        end
        repeat (HALF) @(posedge ref_clk);
        spi_frame_n <= 1'b1;
        // released data line shows the inverse, not a stale bit
        spi_din <= ~spi_din;
        repeat (16) @(posedge ref_clk);
    endtask

    task automatic load_all();
        repeat (40) @(posedge ref_clk);
        load_outputs_n <= 1'b0;
        repeat (8) @(posedge ref_clk);
        load_outputs_n <= 1'b1;
        repeat (8) @(posedge ref_clk);
    endtask
endmodule

// *** tb/tb_top.sv ***
`timescale 1ns/1ps
module tb_top
    import dacrb_pkg::*;
;
    logic               ref_clk;
    logic               rst_b;
    logic               spi_clk;
    logic               spi_frame_n;
    logic               spi_din;
    logic               spi_dout;
    logic               load_outputs_n;
    logic               coding_select;
    logic               over_temp;
    logic               gpio_ext;
    logic               gpio_in;
    logic               gpio_out;
    logic               gpio_oe;
    logic               outputs_powered_down;
    logic               temp_shutdown_en;
    logic [MON_W-1:0]   monitor_select;
    logic [OFS_W-1:0]   group0_offset_level;
    logic [OFS_W-1:0]   group1_offset_level;
    logic [NCH*DW-1:0]  dac_code;
    logic [23:0]        rx;
    int                 mismatches;
    int                 compares;
    int                 cycles;
    localparam int      LIMIT = 60000;

    // pin level resolved from the device enable; gpio_ext drives it otherwise
    assign gpio_in = gpio_oe ? gpio_out : gpio_ext;

    dacrb_bank dacrb_bank_inst (
        .ref_clk(ref_clk), .rst_b(rst_b), .spi_clk(spi_clk), .spi_frame_n(spi_frame_n),
        .spi_din(spi_din), .spi_dout(spi_dout), .load_outputs_n(load_outputs_n),
        .coding_select(coding_select), .over_temp(over_temp), .gpio_in(gpio_in),
        .gpio_out(gpio_out), .gpio_oe(gpio_oe), .outputs_powered_down(outputs_powered_down),
        .temp_shutdown_en(temp_shutdown_en), .monitor_select(monitor_select),
        .group0_offset_level(group0_offset_level),
        .group1_offset_level(group1_offset_level), .dac_code(dac_code)
    );

    dacrb_host dacrb_host_inst (
        .ref_clk(ref_clk), .spi_dout(spi_dout), .spi_clk(spi_clk),
        .spi_frame_n(spi_frame_n), .spi_din(spi_din), .load_outputs_n(load_outputs_n)
    );

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic check(input string name, input logic [23:0] seen, input logic [23:0] exp);
        compares++;
        if (seen !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic wr(input logic [2:0] kind, input logic [3:0] ch, input logic [15:0] data);
        dacrb_host_inst.xfer({1'b0, kind, ch, data}, 24, rx);
    endtask

    // reply comes in the following frame, which is itself a harmless unknown read
    task automatic rd(input logic [2:0] kind, input logic [3:0] ch, input string name,
                      input logic [15:0] exp);
        dacrb_host_inst.xfer({1'b1, kind, ch, 16'h0000}, 24, rx);
        dacrb_host_inst.xfer({1'b1, 3'h7, 4'h0, 16'h0000}, 24, rx);
        check(name, rx, {8'h00, exp});
    endtask

    function automatic logic [15:0] code(input int ch);
        return dac_code[16*ch +: 16];
    endfunction

    task automatic summarize();
        $display("mismatches=%0d compares=%0d", mismatches, compares);
        if (mismatches == 0 && compares > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    always @(posedge ref_clk) begin
        cycles <= cycles + 1;
        if (cycles == LIMIT) begin
            mismatches++;
            summarize();
        end
    end

    initial begin
        rst_b = 1'b0;
        coding_select = 1'b0;
        over_temp = 1'b0;
        gpio_ext = 1'b0;
        mismatches = 0;
        compares = 0;
        cycles = 0;
        repeat (2) @(posedge ref_clk);
        rst_b <= 1'b1;
        repeat (6) @(posedge ref_clk);
        for (int i = 0; i < NCH; i++) check("dac_reset", code(i), 16'h8000);
        check("grp0_reset", group0_offset_level, 14'h2000);
        wr(KIND_SPECIAL, SPC_GRP0_OFS, 16'hFFFF);
        check("grp0", group0_offset_level, 14'h3FFF);
        rd(KIND_SPECIAL, SPC_GRP0_OFS, "grp0_rd", 16'h3FFF);
        wr(KIND_SPECIAL, SPC_GRP1_OFS, 16'h1234);
        check("grp1", group1_offset_level, 14'h1234);
        check("grp0_kept", group0_offset_level, 14'h3FFF);
        wr(KIND_SPECIAL, SPC_MONITOR, 16'hFFFF);
        check("mon_chan", monitor_select, 6'h3F);
        wr(KIND_SPECIAL, SPC_MONITOR, 16'h0031);
        check("mon_ext", monitor_select, 6'h31);
        rd(KIND_SPECIAL, SPC_MONITOR, "mon_rd", 16'h0031);
        over_temp <= 1'b1;
        wr(KIND_SPECIAL, SPC_CONTROL, 16'h0001);
        check("tsd_en", temp_shutdown_en, 1'b1);
        check("tsd_down", outputs_powered_down, 1'b1);
        rd(KIND_SPECIAL, SPC_CONTROL, "ctl_hot", 16'h0011);
        over_temp <= 1'b0;
        wr(KIND_SPECIAL, SPC_CONTROL, 16'h0000);
        check("tsd_off", outputs_powered_down, 1'b0);
        wr(KIND_SPECIAL, SPC_CONTROL, 16'h0002);
        check("soft_down", outputs_powered_down, 1'b1);
        wr(KIND_SPECIAL, SPC_CONTROL, 16'h0000);
        check("soft_up", outputs_powered_down, 1'b0);
        dacrb_host_inst.xfer(24'hFFFFFF, 12, rx);
        rd(KIND_SPECIAL, SPC_CONTROL, "pkt_set", 16'h0008);
        rd(KIND_SPECIAL, SPC_CONTROL, "pkt_clr", 16'h0000);
        wr(KIND_SPECIAL, SPC_GPIO, 16'h0003);
        check("gpio_oe", gpio_oe, 1'b1);
        check("gpio_out", gpio_out, 1'b1);
        gpio_ext <= 1'b1;
        wr(KIND_SPECIAL, SPC_GPIO, 16'h0000);
        check("gpio_in_dir", gpio_oe, 1'b0);
        rd(KIND_SPECIAL, SPC_GPIO, "gpio_rd", 16'h0001);
        wr(KIND_INPUT, 4'h3, 16'h1234);
        wr(KIND_GAIN, 4'h5, 16'h7FFF);
        wr(KIND_OFFS, 4'h9, 16'h8010);
        repeat (40) @(posedge ref_clk);
        check("no_load", code(3), 16'h8000);
        dacrb_host_inst.load_all();
        check("cal_in", code(3), 16'h1234);
        check("cal_gain", code(5), 16'h4000);
        check("cal_offs", code(9), 16'h8010);
        rd(KIND_GAIN, 4'h5, "gain_rd", 16'h7FFF);
        rd(KIND_OFFS, 4'h9, "offs_rd", 16'h8010);
        wr(KIND_SPECIAL, SPC_CONTROL, 16'h0004);
        wr(KIND_INPUT, 4'h3, 16'hABCD);
        dacrb_host_inst.load_all();
        check("bank_a_kept", code(3), 16'h1234);
        wr(KIND_SPECIAL, SPC_ABSEL0, 16'h0008);
        wr(KIND_SPECIAL, SPC_ABSEL1, 16'h0002);
        dacrb_host_inst.load_all();
        check("bank_b_sel", code(3), 16'hABCD);
        check("grp1_sel", code(9), 16'h8000);
        rd(KIND_SPECIAL, SPC_ABSEL1, "sel1_rd", 16'h0002);
        rd(KIND_INPUT, 4'h3, "in_a_rd", 16'h1234);
        rd(KIND_INPUT_B, 4'h3, "in_b_rd", 16'hABCD);
        wr(KIND_SPECIAL, SPC_ABSEL0, 16'h0000);
        wr(KIND_SPECIAL, SPC_CONTROL, 16'h0000);
        dacrb_host_inst.load_all();
        check("bank_a_back", code(3), 16'h1234);
        coding_select <= 1'b1;
        wr(KIND_INPUT, 4'h0, 16'h0001);
        coding_select <= 1'b0;
        rd(KIND_INPUT, 4'h0, "twos_rd", 16'h8001);
        dacrb_host_inst.load_all();
        check("twos_dac", code(0), 16'h8001);
        summarize();
    end
endmodule
